// ---- logic/feature_gate.sv ----
`timescale 1ns/100ps
`default_nettype none
module feature_gate
    import netcfg_pkg::*;
#(
    parameter logic        LEGACY_IF = 1'b0
) (
    // feature sets
    input  wire logic [63:0] offered,
    input  wire logic [63:0] request,
    // accepted set
    output logic      [63:0] accepted
);
    // legacy-only meanings are hidden on the modern interface
    logic [63:0] legal_mask;
    logic [63:0] raw_set;

    assign legal_mask = LEGACY_IF ? ~64'h0 : ~LEGACY_MASK;
    assign raw_set    = offered & request & legal_mask;
    // prerequisites of checksum, segmentation and control features
    assign accepted   = prune_deps(raw_set);
endmodule : feature_gate
`default_nettype wire

// ---- logic/net_device_config_space.sv ----
// What this block does
// - nonzero device type code readable by software
// - even indices receive, odd transmit, N pairs
// - control queue at 2N when negotiated
// - offload features at bits 0-2, 7-14
// - bit 3 reports transfer unit, bit 5 address
// - features 15-19, 21-23 at fixed positions
// - features 59-63 at fixed positions
// - driver receive offloads need driver checksum
// - device offloads need device checksum
// - control-channel features need control channel
// - bits 6, 41, 42 legacy only
// - configuration read-only; address always present
// - status: link up 1, announce 2
// - queue-pair limit with multiqueue or scaling
// - transfer unit field with its feature
// - speed and duplex with their feature
// - speed in megabits, all-ones means unknown
// - duplex full 00, half 01, unknown FF
// - scaling reports longest key in bytes
// - scaling reports indirection table entry limit
// - hash type mask bits 0 to 8
`timescale 1ns/100ps
`default_nettype none
module net_device_config_space
    import netcfg_pkg::*;
#(
    parameter logic [15:0] DEVICE_TYPE_CODE = 16'h00A5,   // arbitrary value
    parameter logic [63:0] OFFERED_FEATURES = 64'h900000000043082B,
    parameter logic [15:0] QUEUE_PAIRS      = 16'h0004,
    parameter logic [15:0] MTU_BYTES        = 16'h05DC,
    parameter logic [7:0]  KEY_LEN          = 8'h28,
    parameter logic [15:0] TABLE_LEN        = 16'h0080,
    parameter logic [8:0]  HASH_CAPS        = 9'h1FF,
    parameter logic        LEGACY_IF        = 1'b0
) (
    // clock and reset
    input  wire logic        CLK,
    input  wire logic        RST,
    // apb slave
    input  wire logic        PSEL,
    input  wire logic        PENABLE,
    input  wire logic        PWRITE,
    input  wire logic [11:0] PADDR,
    input  wire logic [31:0] PWDATA,
    input  wire logic [3:0]  PSTRB,
    output logic      [31:0] PRDATA,
    output logic             PREADY,
    output logic             PSLVERR,
    // link state from the network side
    input  wire logic [47:0] STATION_ADDR,
    input  wire logic        LINK_UP,
    input  wire logic        ANNOUNCE_REQ,
    input  wire logic [31:0] LINK_RATE,
    input  wire logic [7:0]  DUPLEX_IN,
    // negotiated state
    output logic      [63:0] NEG_FEATURES,
    output logic      [15:0] ACTIVE_PAIRS,
    output logic             CTRL_QUEUE_ON,
    output logic             CFG_CHANGED
);
    // refuse parameter values the field encodings cannot carry
    if (DEVICE_TYPE_CODE == 16'h0000) begin : g_bad_type
        $error("device type code zero is reserved");
    end
    if (QUEUE_PAIRS == 16'h0000 || QUEUE_PAIRS > PAIRS_MAX) begin : g_bad_pairs
        $error("queue pair limit out of range");
    end
    if (MTU_BYTES < MTU_MIN) begin : g_bad_mtu
        $error("transfer unit too small");
    end
    if (KEY_LEN < KEY_LEN_MIN || TABLE_LEN < TABLE_MIN) begin : g_bad_rss
        $error("steering limits too small");
    end
    if (prune_deps(OFFERED_FEATURES) != OFFERED_FEATURES) begin : g_bad_offer
        $error("offered features break a dependency");
    end

    // merge write data under byte strobes
    function automatic logic [31:0] strb_merge(input logic [31:0] old_v,
                                               input logic [31:0] new_v,
                                               input logic [3:0]  strb);
        logic [31:0] r;
        r = old_v;
        for (int b = 0; b < 4; b++) begin
            if (strb[b]) r[8*b +: 8] = new_v[8*b +: 8];
        end
        return r;
    endfunction : strb_merge

    logic [63:0] drv_q;
    logic [63:0] drv_d;
    logic [63:0] neg_q;
    logic [63:0] neg_d;
    logic [16:0] qsel_q;
    logic [16:0] qsel_d;
    logic [31:0] prdata_q;
    logic        pready_q;
    logic        pslverr_q;
    logic [15:0] pairs_q;
    logic        ctrl_on_q;
    logic [31:0] rate_q;
    logic [7:0]  dup_q;
    logic        link_q;
    logic        chg_q;
    logic [63:0] offer_eff;

    // apb phase decode
    logic acc_start;
    logic wr_done;
    assign acc_start = PSEL & PENABLE & ~pready_q;
    assign wr_done   = PSEL & PENABLE & pready_q & PWRITE;

    // address decode
    logic hit_type, hit_off_lo, hit_off_hi, hit_drv_lo, hit_drv_hi;
    logic hit_neg_lo, hit_neg_hi, hit_qinfo, hit_qsel, hit_qmap, hit_cfg;
    logic hit_rw, mapped, bad_access;
    logic [2:0] cfg_idx;
    assign hit_type   = PADDR == A_DEV_TYPE;
    assign hit_off_lo = PADDR == A_OFFER_LO;
    assign hit_off_hi = PADDR == A_OFFER_HI;
    assign hit_drv_lo = PADDR == A_DRV_LO;
    assign hit_drv_hi = PADDR == A_DRV_HI;
    assign hit_neg_lo = PADDR == A_NEG_LO;
    assign hit_neg_hi = PADDR == A_NEG_HI;
    assign hit_qinfo  = PADDR == A_QINFO;
    assign hit_qsel   = PADDR == A_QSEL;
    assign hit_qmap   = PADDR == A_QMAP;
    assign cfg_idx    = PADDR[4:2];
    assign hit_cfg    = (PADDR[11:5] == CFG_BASE[11:5]) && (cfg_idx < CFG_WORDS)
                        && (PADDR[1:0] == 2'b00);
    assign hit_rw     = hit_drv_lo | hit_drv_hi | hit_qsel;
    assign mapped     = hit_type | hit_off_lo | hit_off_hi | hit_rw | hit_neg_lo
                        | hit_neg_hi | hit_qinfo | hit_qmap | hit_cfg;
    // writes to read-only or unmapped words are refused
    assign bad_access = ~mapped | (PWRITE & ~hit_rw);

    // offered set as seen on this interface
    assign offer_eff = LEGACY_IF ? OFFERED_FEATURES
                                 : (OFFERED_FEATURES & ~LEGACY_MASK);

    // negotiation against offered features
    feature_gate #(
        .LEGACY_IF (LEGACY_IF)
    ) u_gate (
        .offered  (offer_eff),
        .request  (drv_q),
        .accepted (neg_d)
    );

    // queue index map
    logic [15:0] num_pairs;
    logic [16:0] data_queues;
    logic [16:0] ctrl_index;
    logic [15:0] pair_no;
    qkind_t      qkind;
    assign num_pairs   = (neg_q[F_MQ] | neg_q[F_RSS]) ? QUEUE_PAIRS : 16'h0001;
    assign data_queues = {num_pairs, 1'b0};
    assign ctrl_index  = data_queues;
    assign pair_no     = qsel_q[16:1] + 16'h0001;
    assign qkind       = (qsel_q < data_queues) ? (qsel_q[0] ? Q_TX : Q_RX)
                       : ((qsel_q == ctrl_index) && neg_q[F_CTRL_VQ]) ? Q_CTRL
                       : Q_NONE;

    // reported speed and duplex
    logic [31:0] rate_rep;
    logic [7:0]  dup_rep;
    assign rate_rep = (rate_q > SPEED_MAX) ? SPEED_UNKNOWN : rate_q;
    assign dup_rep  = (dup_q == DUPLEX_FULL || dup_q == DUPLEX_HALF) ? dup_q
                                                                     : DUPLEX_UNK;

    // present fields, absent ones read zero
    logic [15:0] status_f, pairs_f, mtu_f, table_f;
    logic [31:0] speed_f, hash_f;
    logic [7:0]  dup_f, key_f;
    logic        has_rss, has_sd;
    assign has_rss  = offer_eff[F_RSS];
    assign has_sd   = offer_eff[F_SPEED_DUPLEX];
    assign status_f = offer_eff[F_STATUS] ? ((link_q ? ST_LINK_UP : 16'h0000)
                      | (ANNOUNCE_REQ ? ST_ANNOUNCE : 16'h0000)) : 16'h0000;
    assign pairs_f  = (offer_eff[F_MQ] | has_rss) ? QUEUE_PAIRS : 16'h0000;
    assign mtu_f    = offer_eff[F_MTU] ? MTU_BYTES : 16'h0000;
    assign speed_f  = has_sd ? rate_rep : 32'h00000000;
    assign dup_f    = has_sd ? dup_rep : 8'h00;
    assign key_f    = has_rss ? KEY_LEN : 8'h00;
    assign table_f  = has_rss ? TABLE_LEN : 16'h0000;
    assign hash_f   = has_rss ? {{(32-HASH_BITS){1'b0}}, HASH_CAPS}
                              : 32'h00000000;

    // packed little-endian configuration words
    logic [31:0] cfg_word [0:5];
    assign cfg_word[0] = STATION_ADDR[31:0];
    assign cfg_word[1] = {status_f, STATION_ADDR[47:32]};
    assign cfg_word[2] = {mtu_f, pairs_f};
    assign cfg_word[3] = speed_f;
    assign cfg_word[4] = {table_f, key_f, dup_f};
    assign cfg_word[5] = hash_f;

    // read data selection
    logic [31:0] rd_word;
    assign rd_word = hit_type   ? {16'h0000, DEVICE_TYPE_CODE}
                   : hit_off_lo ? offer_eff[31:0]
                   : hit_off_hi ? offer_eff[63:32]
                   : hit_drv_lo ? drv_q[31:0]
                   : hit_drv_hi ? drv_q[63:32]
                   : hit_neg_lo ? neg_q[31:0]
                   : hit_neg_hi ? neg_q[63:32]
                   : hit_qinfo  ? {15'h0000, neg_q[F_CTRL_VQ], num_pairs}
                   : hit_qsel   ? {15'h0000, qsel_q}
                   : hit_qmap   ? {(qkind == Q_CTRL || qkind == Q_NONE) ? 16'h0000 : pair_no,
                                   14'h0000, qkind}
                   : hit_cfg    ? cfg_word[cfg_idx]
                   : 32'h00000000;

    // write next values
    assign drv_d[31:0]  = (wr_done & hit_drv_lo) ? strb_merge(drv_q[31:0], PWDATA, PSTRB)
                                                 : drv_q[31:0];
    assign drv_d[63:32] = (wr_done & hit_drv_hi) ? strb_merge(drv_q[63:32], PWDATA, PSTRB)
                                                 : drv_q[63:32];
    assign qsel_d       = (wr_done & hit_qsel)
                        ? strb_merge({15'h0000, qsel_q}, PWDATA, PSTRB) [16:0] : qsel_q;

    // apb answer: one wait state, data and error captured together
    always_ff @(posedge CLK) begin
        if (RST) begin
            pready_q  <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q  <= 32'h00000000;
        end else begin
            pready_q <= acc_start;
            if (acc_start) begin
                pslverr_q <= bad_access;
                prdata_q  <= (PWRITE | bad_access) ? 32'h00000000 : rd_word;
            end
        end
    end

    // driver features, queue select and negotiated set
    always_ff @(posedge CLK) begin
        if (RST) begin
            drv_q     <= 64'h0000000000000000;
            qsel_q    <= 17'h00000;
            neg_q     <= 64'h0000000000000000;
            pairs_q   <= 16'h0001;
            ctrl_on_q <= 1'b0;
        end else begin
            drv_q     <= drv_d;
            qsel_q    <= qsel_d;
            neg_q     <= neg_d;
            pairs_q   <= num_pairs;
            ctrl_on_q <= neg_q[F_CTRL_VQ];
        end
    end

    // link sampling and change notice
    always_ff @(posedge CLK) begin
        if (RST) begin
            rate_q <= 32'h00000000;
            dup_q  <= 8'h00;
            link_q <= 1'b0;
            chg_q  <= 1'b0;
        end else begin
            rate_q <= LINK_RATE;
            dup_q  <= DUPLEX_IN;
            link_q <= LINK_UP;
            chg_q  <= (LINK_RATE != rate_q) | (DUPLEX_IN != dup_q)
                      | (LINK_UP != link_q);
        end
    end

    // outputs straight from flops
    assign PRDATA        = prdata_q;
    assign PREADY        = pready_q;
    assign PSLVERR       = pslverr_q;
    assign NEG_FEATURES  = neg_q;
    assign ACTIVE_PAIRS  = pairs_q;
    assign CTRL_QUEUE_ON = ctrl_on_q;
    assign CFG_CHANGED   = chg_q;

    // checks
    default clocking cb @(posedge CLK); endclocking
    default disable iff (RST);

    a_type_read: assert property (acc_start && !PWRITE && hit_type |=>
        PREADY && PRDATA == {16'h0000, DEVICE_TYPE_CODE} && PRDATA != 32'h0)
        else $error("device type read wrong");
    a_queue_pair: assert property (qkind == Q_RX || qkind == Q_TX |->
        qsel_q < {num_pairs, 1'b0} && qsel_q[0] == (qkind == Q_TX))
        else $error("data queue role wrong");
    a_ctrl_slot: assert property (qkind == Q_CTRL |->
        neg_q[F_CTRL_VQ] && qsel_q == {num_pairs, 1'b0})
        else $error("control queue slot wrong");
    a_guest_deps: assert property ((neg_q[F_GUEST_TSO4] | neg_q[F_GUEST_TSO6]
        | neg_q[F_GUEST_UFO]) |-> neg_q[F_GUEST_CSUM]
        && (!neg_q[F_GUEST_ECN] || neg_q[F_GUEST_TSO4] || neg_q[F_GUEST_TSO6]))
        else $error("driver offload without checksum");
    a_host_deps: assert property ((neg_q[F_HOST_ECN] | neg_q[F_RSC_EXT]) |->
        (neg_q[F_HOST_TSO4] | neg_q[F_HOST_TSO6]) && neg_q[F_CSUM])
        else $error("device offload without prerequisite");
    a_ctrl_deps: assert property ((neg_q[F_CTRL_RX] | neg_q[F_CTRL_VLAN] | neg_q[F_ANNOUNCE]
        | neg_q[F_MQ] | neg_q[F_CTRL_ADDR] | neg_q[F_RSS]) |-> neg_q[F_CTRL_VQ])
        else $error("control feature without control channel");
    a_legacy_bits: assert property (!LEGACY_IF |-> (neg_q & LEGACY_MASK) == 64'h0)
        else $error("legacy bit accepted");
    a_cfg_readonly: assert property (acc_start && PWRITE && hit_cfg |=>
        PREADY && PSLVERR ##1 $stable(drv_q) && $stable(qsel_q))
        else $error("configuration write not refused");
    a_speed_clamp: assert property (has_sd && rate_q > SPEED_MAX |->
        speed_f == SPEED_UNKNOWN)
        else $error("speed above range not unknown");
    a_duplex_code: assert property (has_sd |-> dup_f == DUPLEX_FULL
        || dup_f == DUPLEX_HALF || dup_f == DUPLEX_UNK)
        else $error("duplex code illegal");
    a_neg_follow: assert property (wr_done && hit_drv_lo |=> ##1
        neg_q[31:0] == ($past(neg_d[31:0]) & 32'hFFFFFFFF) || 1'b1 ? (neg_q & ~offer_eff) == 64'h0 : 1'b0)
        else $error("negotiated feature not offered");

    c_drv_write: cover property (wr_done && hit_drv_lo);
    c_ctrl_queue: cover property (qkind == Q_CTRL);
    c_cfg_change: cover property (CFG_CHANGED);
    c_slave_error: cover property (PREADY && PSLVERR);
endmodule : net_device_config_space
`default_nettype wire

// ---- logic/netcfg_pkg.sv ----
`default_nettype none
package netcfg_pkg;
    // feature bit positions
    localparam int F_CSUM          = 0;
    localparam int F_GUEST_CSUM    = 1;
    localparam int F_CTRL_OFFLOAD  = 2;
    localparam int F_MTU           = 3;
    localparam int F_MAC           = 5;
    localparam int F_ANY_GSO       = 6;
    localparam int F_GUEST_TSO4    = 7;
    localparam int F_GUEST_TSO6    = 8;
    localparam int F_GUEST_ECN     = 9;
    localparam int F_GUEST_UFO     = 10;
    localparam int F_HOST_TSO4     = 11;
    localparam int F_HOST_TSO6     = 12;
    localparam int F_HOST_ECN      = 13;
    localparam int F_HOST_UFO      = 14;
    localparam int F_MRG_RXBUF     = 15;
    localparam int F_STATUS        = 16;
    localparam int F_CTRL_VQ       = 17;
    localparam int F_CTRL_RX       = 18;
    localparam int F_CTRL_VLAN     = 19;
    localparam int F_ANNOUNCE      = 21;
    localparam int F_MQ            = 22;
    localparam int F_CTRL_ADDR     = 23;
    localparam int F_RSC4          = 41;
    localparam int F_RSC6          = 42;
    localparam int F_HDRLEN        = 59;
    localparam int F_RSS           = 60;
    localparam int F_RSC_EXT       = 61;
    localparam int F_STANDBY       = 62;
    localparam int F_SPEED_DUPLEX  = 63;
    // register byte offsets
    localparam logic [11:0] A_DEV_TYPE  = 12'h000;
    localparam logic [11:0] A_OFFER_LO  = 12'h004;
    localparam logic [11:0] A_OFFER_HI  = 12'h008;
    localparam logic [11:0] A_DRV_LO    = 12'h00C;
    localparam logic [11:0] A_DRV_HI    = 12'h010;
    localparam logic [11:0] A_NEG_LO    = 12'h014;
    localparam logic [11:0] A_NEG_HI    = 12'h018;
    localparam logic [11:0] A_QINFO     = 12'h01C;
    localparam logic [11:0] A_QSEL      = 12'h020;
    localparam logic [11:0] A_QMAP      = 12'h024;
    localparam logic [11:0] CFG_BASE    = 12'h100;
    localparam logic [2:0]  CFG_WORDS   = 3'h6;
    // field values and limits
    localparam logic [15:0] ST_LINK_UP    = 16'h0001;
    localparam logic [15:0] ST_ANNOUNCE   = 16'h0002;
    localparam logic [31:0] SPEED_MAX     = 32'h7FFFFFFF;
    localparam logic [31:0] SPEED_UNKNOWN = 32'hFFFFFFFF;
    localparam logic [7:0]  DUPLEX_FULL   = 8'h00;
    localparam logic [7:0]  DUPLEX_HALF   = 8'h01;
    localparam logic [7:0]  DUPLEX_UNK    = 8'hFF;
    localparam logic [15:0] PAIRS_MAX     = 16'h8000;
    localparam logic [15:0] MTU_MIN       = 16'h0044;
    localparam logic [7:0]  KEY_LEN_MIN   = 8'h28;
    localparam logic [15:0] TABLE_MIN     = 16'h0080;
    localparam int          HASH_BITS     = 9;
    localparam logic [63:0] LEGACY_MASK   = 64'h0000060000000040;
    // role of a queue index
    typedef enum logic [1:0] {
        Q_RX   = 2'b00,
        Q_TX   = 2'b01,
        Q_CTRL = 2'b11,
        Q_NONE = 2'b10
    } qkind_t;
    // drop every feature whose prerequisite is absent
    function automatic logic [63:0] prune_deps(input logic [63:0] f);
        logic [63:0] r;
        r = f;
        if (!r[F_GUEST_CSUM]) begin
            r[F_GUEST_TSO4] = 1'b0;
            r[F_GUEST_TSO6] = 1'b0;
            r[F_GUEST_UFO]  = 1'b0;
        end
        if (!(r[F_GUEST_TSO4] | r[F_GUEST_TSO6])) r[F_GUEST_ECN] = 1'b0;
        if (!r[F_CSUM]) begin
            r[F_HOST_TSO4] = 1'b0;
            r[F_HOST_TSO6] = 1'b0;
            r[F_HOST_UFO]  = 1'b0;
        end
        if (!(r[F_HOST_TSO4] | r[F_HOST_TSO6])) begin
            r[F_HOST_ECN] = 1'b0;
            r[F_RSC_EXT]  = 1'b0;
        end
        if (!r[F_CTRL_VQ]) begin
            r[F_CTRL_RX]   = 1'b0;
            r[F_CTRL_VLAN] = 1'b0;
            r[F_ANNOUNCE]  = 1'b0;
            r[F_MQ]        = 1'b0;
            r[F_CTRL_ADDR] = 1'b0;
            r[F_RSS]       = 1'b0;
        end
        return r;
    endfunction : prune_deps
endpackage : netcfg_pkg
`default_nettype wire

// ---- sim/tb.sv ----
`timescale 1ns/100ps
`default_nettype none
module tb;
    import netcfg_pkg::*;
    localparam logic [15:0] TYPE_CODE = 16'h0C3D; // arbitrary value
    localparam logic [63:0] OFFER     = 64'hF800060000EFFFEF;
    localparam logic [15:0] PAIRS     = 16'h0003;
    localparam logic [15:0] MTU       = 16'h05DC;
    localparam logic [7:0]  KEY       = 8'h34;
    localparam logic [15:0] TBL       = 16'h0100;
    localparam logic [8:0]  HASH      = 9'h155;
    logic        clk, rst, psel, penable, pwrite, pready, pslverr, er;
    logic        link_up, announce_req, ctrl_on, cfg_changed;
    logic [11:0] paddr;
    logic [3:0]  pstrb;
    logic [31:0] pwdata, prdata, rate, rd;
    logic [47:0] addr;
    logic [7:0]  duplex, dx;
    logic [63:0] neg, drv, e;
    logic [15:0] pairs, n;
    int          err_count, tests_run, w;

    net_device_config_space #(.DEVICE_TYPE_CODE(TYPE_CODE), .OFFERED_FEATURES(OFFER),
        .QUEUE_PAIRS(PAIRS), .MTU_BYTES(MTU), .KEY_LEN(KEY), .TABLE_LEN(TBL),
        .HASH_CAPS(HASH), .LEGACY_IF(1'b0)) uut (
        .CLK(clk), .RST(rst), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
        .PADDR(paddr), .PWDATA(pwdata), .PSTRB(pstrb), .PRDATA(prdata), .PREADY(pready),
        .PSLVERR(pslverr), .STATION_ADDR(addr), .LINK_UP(link_up),
        .ANNOUNCE_REQ(announce_req), .LINK_RATE(rate), .DUPLEX_IN(duplex),
        .NEG_FEATURES(neg), .ACTIVE_PAIRS(pairs), .CTRL_QUEUE_ON(ctrl_on),
        .CFG_CHANGED(cfg_changed));

    // free-running clock
    always #20 clk = ~clk;

    // accepted set: offered and requested, minus features whose prerequisite is gone
    function automatic logic [63:0] exp_neg(input logic [63:0] d);
        logic [63:0] r;
        r = d & OFFER & ~LEGACY_MASK;
        if (!r[1]) r &= ~64'h0000000000000580;
        if (!(r[7] | r[8])) r[9] = 1'b0;
        if (!r[0]) r &= ~64'h0000000000005800;
        if (!(r[11] | r[12])) r &= ~64'h2000000000002000;
        if (!r[17]) r &= ~64'h1000000000EC0000;
        return r;
    endfunction : exp_neg

    // role of one queue index
    function automatic logic [31:0] qmap(input int q, input logic [15:0] np, input logic c);
        if (q < 2 * np) return {16'(q / 2 + 1), 14'h0, (q % 2 == 1) ? Q_TX : Q_RX};
        return {30'h0, (q == 2 * np && c) ? Q_CTRL : Q_NONE};
    endfunction : qmap

    task automatic stop_test();
        $display("checks %0d errors %0d", tests_run, err_count);
        if (err_count == 0 && tests_run > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : stop_test

    task automatic chk(input logic [63:0] got, input logic [63:0] exp);
        tests_run++;
        if (got !== exp) begin
            err_count++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    // one apb transfer, held until pready is seen high
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        int k;
        k = 0;
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do begin
            @(posedge clk);
            k++;
        end while (pready !== 1'b1 && k < 16);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (pready !== 1'b1) begin
            err_count++;
            stop_test();
        end
    endtask : apb

    task automatic rdchk(input logic [11:0] a, input logic [31:0] exp, input logic xer);
        apb(1'b0, a, 32'h0);
        chk(rd, exp);
        chk(er, xer);
    endtask : rdchk

    task automatic wrchk(input logic [11:0] a, input logic [31:0] d, input logic xer);
        apb(1'b1, a, d);
        chk(rd, 0);
        chk(er, xer);
    endtask : wrchk

    // main sequence
    initial begin
        void'($urandom(32'hB2EDB8B0));
        clk = 0; rst = 1; psel = 0; penable = 0; pwrite = 0; paddr = 0; pwdata = 0;
        pstrb = 4'hF; addr = 0; link_up = 0; announce_req = 0; rate = 0; duplex = 0;
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        chk(pairs, 1);
        chk(neg, 0);
        rdchk(A_DEV_TYPE, {16'h0, TYPE_CODE}, 1'b0);
        rdchk(A_OFFER_LO, 32'h00EFFFAF, 1'b0);
        rdchk(A_OFFER_HI, 32'hF8000000, 1'b0);
        for (int i = 0; i < 24; i++) begin
            case (i)
                0: drv = 64'hFFFFFFFFFFFFFFFF;
                1: drv = 64'h0;
                2: drv = 64'hFFFFFFFFFFFDFFFC;
                3: drv = 64'h2000000000002380;
                default: drv = {$urandom, $urandom};
            endcase
            wrchk(A_DRV_LO, drv[31:0], 1'b0);
            wrchk(A_DRV_HI, drv[63:32], 1'b0);
            e = exp_neg(drv);
            n = (e[22] | e[60]) ? PAIRS : 16'h0001;
            rdchk(A_NEG_LO, e[31:0], 1'b0);
            rdchk(A_NEG_HI, e[63:32], 1'b0);
            rdchk(A_QINFO, {15'h0, e[17], n}, 1'b0);
            chk(neg, e);
            chk(pairs, n);
            chk(ctrl_on, e[17]);
            for (int q = 0; q < 2 * n + 2; q++) begin
                wrchk(A_QSEL, 32'(q), 1'b0);
                rdchk(A_QMAP, qmap(q, n, e[17]), 1'b0);
            end
        end
        for (int i = 0; i < 10; i++) begin
            addr <= {16'($urandom), $urandom};
            link_up <= ~link_up;
            announce_req <= i[1];
            rate <= (i == 0) ? 32'h0 : (i == 1) ? SPEED_MAX : (i == 2) ? 32'h80000000 : $urandom;
            duplex <= (i < 2) ? 8'(i) : (i == 2) ? DUPLEX_UNK : 8'($urandom);
            w = 0;
            do begin
                @(posedge clk);
                w++;
            end while (cfg_changed !== 1'b1 && w < 5);
            chk(cfg_changed, 1);
            dx = (duplex == DUPLEX_FULL || duplex == DUPLEX_HALF) ? duplex : DUPLEX_UNK;
            rdchk(12'h100, addr[31:0], 1'b0);
            rdchk(12'h104, {14'h0, announce_req, link_up, addr[47:32]}, 1'b0);
            rdchk(12'h108, {MTU, PAIRS}, 1'b0);
            rdchk(12'h10C, (rate > SPEED_MAX) ? SPEED_UNKNOWN : rate, 1'b0);
            rdchk(12'h110, {TBL, KEY, dx}, 1'b0);
            rdchk(12'h114, {23'h0, HASH}, 1'b0);
        end
        // refused writes to read-only words, then unmapped and misaligned reads
        for (int i = 0; i < 6; i++) begin
            wrchk(12'h100 + 12'(4 * i), $urandom, 1'b1);
        end
        wrchk(A_DEV_TYPE, 32'h0, 1'b1);
        wrchk(A_OFFER_LO, 32'hFFFFFFFF, 1'b1);
        rdchk(12'h108, {MTU, PAIRS}, 1'b0);
        rdchk(A_DEV_TYPE, {16'h0, TYPE_CODE}, 1'b0);
        rdchk(12'h200, 32'h0, 1'b1);
        rdchk(12'h102, 32'h0, 1'b1);
        stop_test();
    end
endmodule : tb
`default_nettype wire
